// *** inc/pfs_pkg.sv ***
// Package holding the pin function select register map, field positions and pin tables.
package pfs_pkg;

    // Number of pins covered, port 0 bit 6 up to port 1 bit 6.
    localparam int PIN_COUNT = 9;

    // Register addresses in the extended register space.
    localparam logic [15:0] PIN_P0_6_FUNCTION_SELECT = 16'hA056;
    localparam logic [15:0] PIN_P0_7_FUNCTION_SELECT = 16'hA057;
    localparam logic [15:0] PIN_P1_0_FUNCTION_SELECT = 16'hA058;
    localparam logic [15:0] PIN_P1_1_FUNCTION_SELECT = 16'hA059;
    localparam logic [15:0] PIN_P1_2_FUNCTION_SELECT = 16'hA05A;
    localparam logic [15:0] PIN_P1_3_FUNCTION_SELECT = 16'hA05B;
    localparam logic [15:0] PIN_P1_4_FUNCTION_SELECT = 16'hA05C;
    localparam logic [15:0] PIN_P1_5_FUNCTION_SELECT = 16'hA05D;
    localparam logic [15:0] PIN_P1_6_FUNCTION_SELECT = 16'hA05E;

    localparam logic [15:0] PFS_OFFSET [PIN_COUNT] = '{
        PIN_P0_6_FUNCTION_SELECT, PIN_P0_7_FUNCTION_SELECT, PIN_P1_0_FUNCTION_SELECT,
        PIN_P1_1_FUNCTION_SELECT, PIN_P1_2_FUNCTION_SELECT, PIN_P1_3_FUNCTION_SELECT,
        PIN_P1_4_FUNCTION_SELECT, PIN_P1_5_FUNCTION_SELECT, PIN_P1_6_FUNCTION_SELECT
    };

    // Reset value of every function select register.
    localparam logic [7:0] PFS_RESET = 8'h00;

    // Field positions inside a function select register.
    localparam int GENERAL_IO_SELECT_BIT = 0;
    localparam int PIN_IRQ_A_SELECT_BIT  = 1;
    localparam int PIN_IRQ_B_SELECT_BIT  = 2;
    localparam int ALT_SLOT_LSB          = 4;

    // Analog enable position in the pin buffer configuration register.
    localparam int ANALOG_PATH_ENABLE_BIT = 3;

    // Pin indices of the two RTC crystal pins.
    localparam int RTC_OUT_PIN = 6;
    localparam int RTC_IN_PIN  = 7;

    // Writable bits per pin; unlisted bits hold zero.
    localparam logic [7:0] PFS_WRITE_MASK [PIN_COUNT] = '{
        8'hB7, 8'hB7, 8'hB7, 8'hB7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7
    };

    // Alternate slots (bits 7..4 as 3..0) that drive the pin.
    localparam logic [3:0] PFS_DRIVE_SLOTS [PIN_COUNT] = '{
        4'h3, 4'h0, 4'h3, 4'h3, 4'h7, 4'h7, 4'h7, 4'h7, 4'h3
    };

    // Value seen by a peripheral input while its slot is not selected.
    localparam logic [3:0] PFS_IDLE_IN [PIN_COUNT] = '{
        4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h5, 4'h5, 4'h0
    };

endpackage : pfs_pkg

// *** rtl/pfs_pin_sel.sv ***
// One pin: its function select register and the priority multiplexer on its pad.
module pfs_pin_sel #(
    parameter logic [7:0] WRITE_MASK  = 8'hFF,
    parameter logic [3:0] DRIVE_SLOTS = 4'h0,
    parameter logic [3:0] IDLE_IN     = 4'h0
) (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Register write.
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // Pad side.
    input  wire logic       pin_in,
    output logic            pin_do,
    output logic            pin_oe,
    // Function side.
    input  wire logic [3:0] alt_do,
    input  wire logic [3:0] alt_oe,
    input  wire logic       gpio_do,
    input  wire logic       gpio_oe,
    output logic [3:0]      alt_di,
    output logic            gpio_di,
    output logic            irq_a_cond,
    output logic            irq_b_cond,
    output logic [7:0]      cfg
);

    logic [3:0] slot_sel;
    logic [3:0] slot_drive;
    logic       gpio_sel;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cfg <= pfs_pkg::PFS_RESET;
        else if (wr_en)
            cfg <= wdata & WRITE_MASK;
    end

    assign slot_sel   = cfg[pfs_pkg::ALT_SLOT_LSB +: 4];
    assign slot_drive = slot_sel & DRIVE_SLOTS;
    assign gpio_sel   = cfg[pfs_pkg::GENERAL_IO_SELECT_BIT];

    // A fixed order keeps two selected sources from fighting on the pad.
    assign pin_do = slot_drive[3] ? alt_do[3] :
                    slot_drive[2] ? alt_do[2] :
                    slot_drive[1] ? alt_do[1] :
                    slot_drive[0] ? alt_do[0] :
                    gpio_sel      ? gpio_do   : 1'b0;
    assign pin_oe = slot_drive[3] ? alt_oe[3] :
                    slot_drive[2] ? alt_oe[2] :
                    slot_drive[1] ? alt_oe[1] :
                    slot_drive[0] ? alt_oe[0] :
                    gpio_sel      ? gpio_oe   : 1'b0;

    assign alt_di     = (slot_sel & {4{pin_in}}) | (~slot_sel & IDLE_IN);
    assign gpio_di    = gpio_sel & pin_in;
    // Both conditions are independent so one pin may feed both interrupts.
    assign irq_a_cond = cfg[pfs_pkg::PIN_IRQ_A_SELECT_BIT] & pin_in;
    assign irq_b_cond = cfg[pfs_pkg::PIN_IRQ_B_SELECT_BIT] & pin_in;

endmodule // pfs_pin_sel

// *** rtl/pfs_top.sv ***
// Pin function select block for pins port 0 bit 6 to port 1 bit 6.

module pfs_top (
    // Clock and reset.
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // Extended register space access.
    input  wire logic [15:0]          xfr_addr,
    input  wire logic                 xfr_wr,
    input  wire logic                 xfr_rd,
    input  wire logic [7:0]           xfr_wdata,
    output logic [7:0]                xfr_rdata,
    // Pads.
    input  wire logic [8:0]           pin_in,
    output logic [8:0]                pin_out,
    output logic [8:0]                pin_oe,
    // General-purpose I/O.
    input  wire logic [8:0]           gpio_out,
    input  wire logic [8:0]           gpio_oe,
    output logic [8:0]                gpio_in,
    // Shared pin interrupts.
    output logic                      shared_pin_irq_a,
    output logic                      shared_pin_irq_b,
    // UARTs.
    input  wire logic                 uart_a_tx,
    input  wire logic                 uart_b_tx,
    output logic                      uart_a_rx,
    output logic                      uart_b_rx,
    // Motor PWM unit.
    input  wire logic                 motor_pwm_a_pos,
    input  wire logic                 motor_pwm_a_neg,
    input  wire logic                 motor_pwm_b_pos,
    input  wire logic                 motor_pwm_b_neg,
    // Capture/compare units 0 to 3.
    input  wire logic [3:0]           capcomp_out,
    input  wire logic [3:0]           capcomp_oe,
    output logic [3:0]                capcomp_in,
    // I2C lines; a drive_low input pulls the line low.
    input  wire logic                 i2c_slave_a_data_drive_low,
    input  wire logic                 i2c_slave_a_clock_drive_low,
    input  wire logic                 i2c_slave_b_data_drive_low,
    input  wire logic                 i2c_slave_b_clock_drive_low,
    input  wire logic                 i2c_master_data_drive_low,
    input  wire logic                 i2c_master_clock_drive_low,
    output logic                      i2c_slave_a_data_in,
    output logic                      i2c_slave_a_clock_in,
    output logic                      i2c_slave_b_data_in,
    output logic                      i2c_slave_b_clock_in,
    output logic                      i2c_master_data_in,
    output logic                      i2c_master_clock_in,
    // Timer 1.
    output logic                      timer_one_in,
    // Analog routing.
    output logic                      adc_chan_c_in_select,
    output logic                      adc_chan_d_in2_select,
    output logic                      adc_chan_d_in3_select,
    output logic                      adc_chan_d_in4_select,
    output logic                      adc_chan_d_in7_select,
    output logic                      adc_chan_d_in8_select,
    output logic                      adc_chan_d_in9_select,
    output logic                      rtc_crystal_out_select,
    output logic                      rtc_crystal_in_select,
    // Buffer analog enable.
    input  wire logic [8:0]           buf_analog_sw,
    input  wire logic                 rtc_enable,
    output logic [8:0]                analog_path_enable
);

    localparam int N = pfs_pkg::PIN_COUNT;

    logic [7:0] cfg         [N];
    logic [3:0] alt_do      [N];
    logic [3:0] alt_oe      [N];
    logic [3:0] alt_di      [N];
    logic [N-1:0] hit;
    logic [N-1:0] mux_do;
    logic [N-1:0] mux_oe;
    logic [N-1:0] gpio_di;
    logic [N-1:0] irq_a_cond;
    logic [N-1:0] irq_b_cond;
    logic [7:0] rd_value;
    logic [8:0] next_analog;
    logic [3:0] next_capcomp_in;

    // Alternate sources per pin; slot 3 is bit 7 down to slot 0 at bit 4.
    // I2C functions only ever pull low, so the pad data stays zero there.
    assign alt_do[0] = {1'b0, 1'b0, uart_b_tx, uart_a_tx};
    assign alt_oe[0] = {1'b0, 1'b0, 1'b1, 1'b1};
    assign alt_do[1] = 4'h0;
    assign alt_oe[1] = 4'h0;
    assign alt_do[2] = {1'b0, 1'b0, motor_pwm_a_pos, capcomp_out[0]};
    assign alt_oe[2] = {1'b0, 1'b0, 1'b1, capcomp_oe[0]};
    assign alt_do[3] = {1'b0, 1'b0, motor_pwm_a_neg, capcomp_out[1]};
    assign alt_oe[3] = {1'b0, 1'b0, 1'b1, capcomp_oe[1]};
    assign alt_do[4] = {1'b0, 1'b0, motor_pwm_a_pos, capcomp_out[2]};
    assign alt_oe[4] = {1'b0, i2c_slave_a_data_drive_low, 1'b1, capcomp_oe[2]};
    assign alt_do[5] = {1'b0, 1'b0, motor_pwm_a_neg, capcomp_out[3]};
    assign alt_oe[5] = {1'b0, i2c_slave_a_clock_drive_low, 1'b1, capcomp_oe[3]};
    assign alt_do[6] = {1'b0, 1'b0, motor_pwm_b_pos, 1'b0};
    assign alt_oe[6] = {1'b0, i2c_slave_b_clock_drive_low, 1'b1,
                        i2c_master_clock_drive_low};
    assign alt_do[7] = {1'b0, 1'b0, motor_pwm_b_neg, 1'b0};
    assign alt_oe[7] = {1'b0, i2c_slave_b_data_drive_low, 1'b1,
                        i2c_master_data_drive_low};
    assign alt_do[8] = {1'b0, 1'b0, motor_pwm_b_pos, capcomp_out[0]};
    assign alt_oe[8] = {1'b0, 1'b0, 1'b1, capcomp_oe[0]};

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_pin
            assign hit[gi] = (xfr_addr == pfs_pkg::PFS_OFFSET[gi]);

            pfs_pin_sel #(
                .WRITE_MASK  (pfs_pkg::PFS_WRITE_MASK[gi]),
                .DRIVE_SLOTS (pfs_pkg::PFS_DRIVE_SLOTS[gi]),
                .IDLE_IN     (pfs_pkg::PFS_IDLE_IN[gi])
            ) u_pin (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .wr_en      (xfr_wr & hit[gi]),
                .wdata      (xfr_wdata),
                .pin_in     (pin_in[gi]),
                .pin_do     (mux_do[gi]),
                .pin_oe     (mux_oe[gi]),
                .alt_do     (alt_do[gi]),
                .alt_oe     (alt_oe[gi]),
                .gpio_do    (gpio_out[gi]),
                .gpio_oe    (gpio_oe[gi]),
                .alt_di     (alt_di[gi]),
                .gpio_di    (gpio_di[gi]),
                .irq_a_cond (irq_a_cond[gi]),
                .irq_b_cond (irq_b_cond[gi]),
                .cfg        (cfg[gi])
            );
        end
    endgenerate

    // Unmapped addresses read back as zero.
    always_comb
    begin
        rd_value = 8'h00;
        for (int i = 0; i < N; i++)
        begin
            if (hit[i])
                rd_value = cfg[i];
        end
    end

    // Software owns the analog switch, but a running RTC needs its crystal pins analog.
    always_comb
    begin
        next_analog = buf_analog_sw;
        if (rtc_enable)
        begin
            next_analog[pfs_pkg::RTC_OUT_PIN] = 1'b1;
            next_analog[pfs_pkg::RTC_IN_PIN]  = 1'b1;
        end
    end

    // Capture/compare 0 may sit on two pins; idle value zero lets them merge.
    assign next_capcomp_in = {alt_di[5][0], alt_di[4][0], alt_di[3][0],
                              alt_di[2][0] | alt_di[8][0]};

    // Register read data; one cycle after the read strobe.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            xfr_rdata <= 8'h00;
        else if (xfr_rd)
            xfr_rdata <= rd_value;
    end

    // Pad outputs; registered so nothing combinational reaches a pad.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_out <= 9'h000;
            pin_oe  <= 9'h000;
            gpio_in <= 9'h000;
        end
        else
        begin
            pin_out <= mux_do;
            pin_oe  <= mux_oe;
            gpio_in <= gpio_di;
        end
    end

    // Shared interrupts collect any number of pins.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            shared_pin_irq_a <= 1'b0;
            shared_pin_irq_b <= 1'b0;
        end
        else
        begin
            shared_pin_irq_a <= |irq_a_cond;
            shared_pin_irq_b <= |irq_b_cond;
        end
    end

    // Digital peripheral inputs.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            uart_a_rx  <= 1'b0;
            uart_b_rx  <= 1'b0;
            capcomp_in <= 4'h0;
            timer_one_in <= 1'b0;
        end
        else
        begin
            uart_a_rx  <= alt_di[1][0];
            uart_b_rx  <= alt_di[1][1];
            capcomp_in <= next_capcomp_in;
            timer_one_in <= alt_di[8][2];
        end
    end

    // I2C inputs idle high while unselected, so a dropped pin never looks like a start.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            i2c_slave_a_data_in  <= 1'b1;
            i2c_slave_a_clock_in <= 1'b1;
            i2c_slave_b_clock_in <= 1'b1;
            i2c_slave_b_data_in  <= 1'b1;
            i2c_master_clock_in  <= 1'b1;
            i2c_master_data_in   <= 1'b1;
        end
        else
        begin
            i2c_slave_a_data_in  <= alt_di[4][2];
            i2c_slave_a_clock_in <= alt_di[5][2];
            i2c_slave_b_clock_in <= alt_di[6][2];
            i2c_slave_b_data_in  <= alt_di[7][2];
            i2c_master_clock_in  <= alt_di[6][0];
            i2c_master_data_in   <= alt_di[7][0];
        end
    end

    // Analog switch selects follow bit 7 of each register.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            adc_chan_c_in_select   <= 1'b0;
            adc_chan_d_in2_select  <= 1'b0;
            adc_chan_d_in3_select  <= 1'b0;
            adc_chan_d_in4_select  <= 1'b0;
            adc_chan_d_in7_select  <= 1'b0;
            adc_chan_d_in8_select  <= 1'b0;
            adc_chan_d_in9_select  <= 1'b0;
            rtc_crystal_out_select <= 1'b0;
            rtc_crystal_in_select  <= 1'b0;
            analog_path_enable     <= 9'h000;
        end
        else
        begin
            adc_chan_c_in_select   <= cfg[0][7];
            adc_chan_d_in2_select  <= cfg[1][7];
            adc_chan_d_in3_select  <= cfg[2][7];
            adc_chan_d_in4_select  <= cfg[3][7];
            adc_chan_d_in7_select  <= cfg[4][7];
            adc_chan_d_in8_select  <= cfg[5][7];
            adc_chan_d_in9_select  <= cfg[8][7];
            rtc_crystal_out_select <= cfg[6][7];
            rtc_crystal_in_select  <= cfg[7][7];
            analog_path_enable     <= next_analog;
        end
    end

endmodule // pfs_top

// *** tb/pfs_top_monitor.sv ***
// Checker for the pin function select block, bound to its top module.
module pfs_top_monitor (
    // Clock and reset.
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register access.
    input wire logic [15:0] xfr_addr,
    input wire logic        xfr_wr,
    input wire logic        xfr_rd,
    input wire logic [7:0]  xfr_wdata,
    input wire logic [7:0]  xfr_rdata,
    // Pads and functions.
    input wire logic [8:0]  pin_in,
    input wire logic [8:0]  pin_out,
    input wire logic [8:0]  pin_oe,
    input wire logic [8:0]  gpio_in,
    input wire logic        shared_pin_irq_a,
    input wire logic        shared_pin_irq_b,
    input wire logic        uart_b_tx,
    input wire logic        motor_pwm_b_pos,
    input wire logic        i2c_slave_b_clock_drive_low,
    input wire logic        adc_chan_c_in_select,
    input wire logic        rtc_crystal_out_select,
    input wire logic [8:0]  buf_analog_sw,
    input wire logic        rtc_enable,
    input wire logic [8:0]  analog_path_enable
);
    // Shadow of the registers built from bus writes, so checks never trust a readback.
    logic [7:0] shadow [9];
    logic [7:0] rd_exp;
    logic [8:0] sel_io;
    logic [8:0] sel_a;
    logic [8:0] sel_b;

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < 9; i++)
        begin
            if (rst)
                shadow[i] <= 8'h00;
            else if (xfr_wr && xfr_addr == pfs_pkg::PFS_OFFSET[i])
                shadow[i] <= xfr_wdata & ((i < 4) ? 8'hB7 : 8'hF7);
        end
    end

    always_comb
    begin
        rd_exp = 8'h00;
        for (int i = 0; i < 9; i++)
        begin
            if (xfr_addr == pfs_pkg::PFS_OFFSET[i])
                rd_exp = shadow[i];
            sel_io[i] = shadow[i][0];
            sel_a[i] = shadow[i][1];
            sel_b[i] = shadow[i][2];
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_read_data: assert property (xfr_rd |=> xfr_rdata == $past(rd_exp))
        else $error("read data differs from written value");
    a_irq_a_or: assert property (shared_pin_irq_a == $past(|(pin_in & sel_a)))
        else $error("first shared interrupt wrong");
    a_irq_b_or: assert property (shared_pin_irq_b == $past(|(pin_in & sel_b)))
        else $error("second shared interrupt wrong");
    a_gpio_gate: assert property (gpio_in == $past(pin_in & sel_io))
        else $error("general input not gated by its select");
    a_pwm_drive: assert property ($past(shadow[6][6:5] == 2'b01) |->
        pin_oe[6] && pin_out[6] == $past(motor_pwm_b_pos))
        else $error("pwm slot does not drive its pin");
    a_i2c_wins: assert property ($past(shadow[6][6]) |->
        !pin_out[6] && pin_oe[6] == $past(i2c_slave_b_clock_drive_low))
        else $error("i2c slot does not win the pin");
    a_uart_tx: assert property ($past(shadow[0][5]) |->
        pin_oe[0] && pin_out[0] == $past(uart_b_tx))
        else $error("uart transmit slot does not drive its pin");
    a_idle_pin: assert property ($past(shadow[1][0] == 1'b0) |-> !pin_oe[1])
        else $error("receive-only pin driven");
    a_select_copy: assert property (adc_chan_c_in_select == $past(shadow[0][7]) &&
        rtc_crystal_out_select == $past(shadow[6][7]))
        else $error("analog select does not follow bit 7");
    a_rtc_force: assert property (rtc_enable |=> &analog_path_enable[7:6])
        else $error("analog enable not forced while clock runs");
    a_analog_pass: assert property (!rtc_enable |=>
        analog_path_enable == $past(buf_analog_sw))
        else $error("analog enable does not follow software");
endmodule // pfs_top_monitor

bind pfs_top pfs_top_monitor u_monitor (.*);

// *** tb/pfs_board.sv ***
// Board model: pads show what the block drives, else the level of the board.
module pfs_board (
    // Pad side of the block.
    input  wire logic [8:0] pin_out,
    input  wire logic [8:0] pin_oe,
    // Level held by the board where the block does not drive.
    input  wire logic [8:0] ext_level,
    output logic [8:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // An undriven pad takes the board level, never a stale driven value.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pfs_board

// *** tb/test_pfs_top.sv ***
// Self-checking testbench for the pin function select block.
module test_pfs_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, xfr_wr, xfr_rd, rtc_enable, timer_one_in;
    logic        uart_a_tx, uart_b_tx, uart_a_rx, uart_b_rx, shared_pin_irq_a, shared_pin_irq_b;
    logic        motor_pwm_a_pos, motor_pwm_a_neg, motor_pwm_b_pos, motor_pwm_b_neg;
    logic        i2c_slave_a_data_drive_low, i2c_slave_a_clock_drive_low;
    logic        i2c_slave_b_data_drive_low, i2c_slave_b_clock_drive_low;
    logic        i2c_master_data_drive_low, i2c_master_clock_drive_low;
    logic        i2c_slave_a_data_in, i2c_slave_a_clock_in, i2c_slave_b_data_in;
    logic        i2c_slave_b_clock_in, i2c_master_data_in, i2c_master_clock_in;
    logic        adc_chan_c_in_select, adc_chan_d_in2_select, adc_chan_d_in3_select;
    logic        adc_chan_d_in4_select, adc_chan_d_in7_select, adc_chan_d_in8_select;
    logic        adc_chan_d_in9_select, rtc_crystal_out_select, rtc_crystal_in_select;
    logic [15:0] xfr_addr;
    logic [7:0]  xfr_wdata, xfr_rdata;
    logic [8:0]  pin_in, pin_out, pin_oe, gpio_out, gpio_oe, gpio_in;
    logic [8:0]  buf_analog_sw, analog_path_enable, ext_level;
    logic [3:0]  capcomp_out, capcomp_oe, capcomp_in;
    int          err_count = 0;
    int          n_compared = 0;

    pfs_top DUT (.*);
    pfs_board u_board (.pin_out, .pin_oe, .ext_level, .pin_in);

    always #25 clk_sys = ~clk_sys;

    task automatic check(string what, logic [8:0] seen, logic [8:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        tick(1);
        xfr_addr = a;
        xfr_wdata = d;
        xfr_wr = 1'b1;
        tick(1);
        xfr_wr = 1'b0;
    endtask

    task automatic rd(logic [15:0] a, logic [7:0] exp);
        tick(1);
        xfr_addr = a;
        xfr_rd = 1'b1;
        tick(1);
        xfr_rd = 1'b0;
        check("read data", xfr_rdata, exp);
    endtask

    // Fixed waits only; this bound catches any hang.
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        finish_test();
    end

    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {xfr_wr, xfr_rd, rtc_enable, uart_a_tx, uart_b_tx, motor_pwm_a_pos} = '0;
        {motor_pwm_a_neg, motor_pwm_b_pos, motor_pwm_b_neg, i2c_slave_a_data_drive_low} = '0;
        {i2c_slave_a_clock_drive_low, i2c_slave_b_data_drive_low} = '0;
        {i2c_slave_b_clock_drive_low, i2c_master_data_drive_low, i2c_master_clock_drive_low} = '0;
        {xfr_addr, xfr_wdata, gpio_out, gpio_oe, buf_analog_sw, ext_level} = '0;
        {capcomp_out, capcomp_oe} = '0;
        tick(16);
        rst = 1'b0;
        for (int i = 0; i < 9; i++)
            rd(pfs_pkg::PFS_OFFSET[i], 8'h00);
        check("pad enables", pin_oe, 9'h000);
        for (int i = 0; i < 9; i++)
            wr(pfs_pkg::PFS_OFFSET[i], 8'hFF);
        wr(16'hA05F, 8'hFF);
        for (int i = 0; i < 9; i++)
            rd(pfs_pkg::PFS_OFFSET[i], (i < 4) ? 8'hB7 : 8'hF7);
        rd(16'hA05F, 8'h00);
        rd(16'hA055, 8'h00);
        i2c_slave_b_clock_drive_low = 1'b1;
        tick(1);
        check("i2c pad", {pin_oe[6], pin_out[6]}, 9'h002);
        $display("test registers done");
        // General-purpose I/O on every pin.
        for (int i = 0; i < 9; i++)
            wr(pfs_pkg::PFS_OFFSET[i], 8'h01);
        gpio_oe = 9'h0F0;
        gpio_out = 9'h1A5;
        ext_level = 9'h05A;
        tick(2);
        check("gpio enable", pin_oe, 9'h0F0);
        check("gpio out", pin_out & 9'h0F0, 9'h0A0);
        check("gpio in", gpio_in, 9'h0AA);
        $display("test gpio done");
        // Shared interrupts from P0.6 (both) and P1.6 (first only).
        gpio_oe = 9'h000;
        for (int i = 0; i < 9; i++)
            wr(pfs_pkg::PFS_OFFSET[i], (i == 0) ? 8'h06 : (i == 8) ? 8'h02 : 8'h00);
        ext_level = 9'h100;
        tick(2);
        check("irq pair p16", {shared_pin_irq_a, shared_pin_irq_b}, 9'h002);
        ext_level = 9'h001;
        tick(2);
        check("irq pair p06", {shared_pin_irq_a, shared_pin_irq_b}, 9'h003);
        ext_level = 9'h0FE;
        tick(2);
        check("irq pair off", {shared_pin_irq_a, shared_pin_irq_b}, 9'h000);
        $display("test interrupts done");
        // Priority on P1.4 and P0.6, receive on P0.7.
        wr(16'hA05C, 8'h30);
        wr(16'hA056, 8'h30);
        wr(16'hA057, 8'h10);
        motor_pwm_b_pos = 1'b1;
        uart_b_tx = 1'b1;
        ext_level = 9'h002;
        tick(2);
        check("pwm pad", {pin_oe[6], pin_out[6]}, 9'h003);
        check("uart pad", {pin_oe[0], pin_out[0]}, 9'h003);
        check("uart rx", {uart_a_rx, uart_b_rx}, 9'h002);
        wr(16'hA05C, 8'h70);
        i2c_slave_b_clock_drive_low = 1'b0;
        tick(2);
        check("i2c release", {pin_oe[6], i2c_slave_b_clock_in}, 9'h000);
        $display("test priority done");
        // Bit 7 of every register and the timer input.
        for (int i = 0; i < 9; i++)
            wr(pfs_pkg::PFS_OFFSET[i], 8'h80);
        wr(16'hA05E, 8'hC0);
        ext_level = 9'h100;
        tick(2);
        check("analog selects", {adc_chan_c_in_select, adc_chan_d_in2_select,
            adc_chan_d_in3_select, adc_chan_d_in4_select, adc_chan_d_in7_select,
            adc_chan_d_in8_select, rtc_crystal_out_select, rtc_crystal_in_select,
            adc_chan_d_in9_select}, 9'h1FF);
        check("timer input", timer_one_in, 9'h001);
        // Crystal pins are left to the running RTC to force analog.
        buf_analog_sw = 9'h13F;
        tick(2);
        check("analog enable", analog_path_enable, 9'h13F);
        rtc_enable = 1'b1;
        tick(2);
        check("analog forced", analog_path_enable, 9'h1FF);
        $display("test analog done");
        // Digital peripherals and open-drain lines on port 1.
        wr(16'hA058, 8'h10);
        wr(16'hA059, 8'h20);
        wr(16'hA05A, 8'h40);
        wr(16'hA05B, 8'h10);
        wr(16'hA05C, 8'h10);
        wr(16'hA05D, 8'h40);
        wr(16'hA05E, 8'h10);
        {capcomp_oe, capcomp_out} = 8'h99;
        motor_pwm_a_neg = 1'b1;
        i2c_slave_a_data_drive_low = 1'b1;
        ext_level = 9'h03F;
        tick(2);
        check("port 1 enables", pin_oe, 9'h13C);
        check("port 1 data", pin_out, 9'h12C);
        check("capture inputs", capcomp_in, 9'h009);
        check("i2c inputs", {i2c_slave_a_data_in, i2c_slave_a_clock_in,
            i2c_slave_b_data_in, i2c_slave_b_clock_in, i2c_master_clock_in,
            i2c_master_data_in}, 9'h015);
        $display("test peripherals done");
        // A second reset in mid-run clears the registers again.
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rd(16'hA05E, 8'h00);
        check("i2c idle", {i2c_slave_a_data_in, i2c_slave_a_clock_in,
            i2c_slave_b_data_in, i2c_slave_b_clock_in, i2c_master_clock_in,
            i2c_master_data_in}, 9'h03F);
        $display("test second reset done");
        finish_test();
    end
endmodule // test_pfs_top
